// >>> hw/bfs_pkg.sv
// Package with timing constants and state type for the buck fault sequencer
package bfs_pkg;
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned UV_QUAL_US      = 25;
    localparam int unsigned PG_BLANK_US     = 25;
    localparam int unsigned HICCUP_SS_COUNT = 20;
    localparam int unsigned UV_QUAL_CYC     = UV_QUAL_US * CLK_MHZ;
    localparam int unsigned PG_BLANK_CYC    = PG_BLANK_US * CLK_MHZ;
    localparam int unsigned CNT_W           = 32;
    localparam int unsigned HIC_W           = 5;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 32'h0;
    localparam logic [CNT_W-1:0] CNT_ONE    = 32'h1;
    localparam logic [HIC_W-1:0] HIC_ZERO   = 5'h0;
    localparam logic [HIC_W-1:0] HIC_ONE    = 5'h1;
    localparam int unsigned SS_DEFAULT_CYC  = 100000;
    localparam int unsigned SYNC_N          = 10;
    localparam int unsigned SYNC_EN         = 9;
    localparam int unsigned SYNC_LOCKOUT    = 8;
    localparam int unsigned SYNC_FB_UNDER   = 7;
    localparam int unsigned SYNC_FB_OVER    = 6;
    localparam int unsigned SYNC_FB_WIN     = 5;
    localparam int unsigned SYNC_FB_ABOVE   = 4;
    localparam int unsigned SYNC_HOT        = 3;
    localparam int unsigned SYNC_COOL       = 2;
    localparam int unsigned SYNC_DCM        = 1;
    localparam int unsigned SYNC_VALLEY     = 0;

    typedef enum logic [2:0] {
        BFS_OFF,
        BFS_SOFT_START,
        BFS_RUN,
        BFS_HICCUP,
        BFS_THERMAL
    } bfs_state_e;
endpackage

// >>> hw/bfs_qual_cnt.sv
// Qualification counter: output rises after condition holds for a number of cycles
`timescale 1ns/1ps
`default_nettype none
module bfs_qual_cnt (
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     en_i,
    input  wire logic                     cond_i,
    input  wire logic [bfs_pkg::CNT_W-1:0] limit_i,
    output logic                          hit_o
);
    logic [bfs_pkg::CNT_W-1:0] cnt_q;

    // Restart whenever the condition drops before expiry
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= bfs_pkg::CNT_ZERO;
            hit_o <= 1'b0;
        end else if (en_i) begin
            if (!cond_i) begin
                cnt_q <= bfs_pkg::CNT_ZERO;
                hit_o <= 1'b0;
            end else if (cnt_q >= limit_i) begin
                hit_o <= 1'b1;
            end else begin
                cnt_q <= cnt_q + bfs_pkg::CNT_ONE;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/bfs_sequencer.sv
// Buck regulator start-up, fault and power-good sequencer
// Notes on behaviour
// - Undervoltage held past qualification trips both switches
// - Undervoltage hiccup waits twenty soft starts, retries
// - Undervoltage ignored until soft start completes
// - Overvoltage flag turns both switches off
// - Overvoltage clear resumes switching without soft start
// - Overvoltage armed from lockout release, incl. soft start
// - Thermal hot turns both switches off
// - Thermal restart waits for cool, then soft start
// - Thermal shutdown masked during discontinuous conduction
// - Enable high runs, enable low shuts down
// - Soft-start reference ramps after lockout release
// - Soft-start reference replaces fixed reference meanwhile
// - Valley current limit active during soft start
// - Short-circuit trip disarmed until soft start done
// - Pre-biased output blocks switching during start-up
// - Power good low when feedback leaves window
// - Power good changes in run blanked for fixed interval
// - Valley over-limit keeps high side off
`timescale 1ns/1ps
`default_nettype none
module bfs_sequencer #(
    parameter int unsigned UV_QUAL_CYC  = bfs_pkg::UV_QUAL_CYC,
    parameter int unsigned PG_BLANK_CYC = bfs_pkg::PG_BLANK_CYC,
    parameter int unsigned SS_CYC       = bfs_pkg::SS_DEFAULT_CYC
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic clk_en_i,
    input  wire logic enable_i,
    input  wire logic supply_lockout_i,
    input  wire logic fb_under_i,
    input  wire logic fb_over_i,
    input  wire logic fb_in_window_i,
    input  wire logic fb_above_ramp_i,
    input  wire logic thermal_hot_i,
    input  wire logic thermal_cool_i,
    input  wire logic dcm_i,
    input  wire logic valley_over_limit_i,
    output logic      high_side_switch_en_o,
    output logic      low_side_switch_en_o,
    output logic      soft_start_ramp_o,
    output logic      use_soft_start_reference_o,
    output logic      valley_current_limit_en_o,
    output logic      short_circuit_trip_en_o,
    output logic      undervoltage_trip_o,
    output logic      overvoltage_trip_o,
    output logic      thermal_trip_o,
    output logic      power_good_out_o,
    output logic      power_good_out_oe_o
);
    localparam logic [bfs_pkg::CNT_W-1:0] UV_LIM = UV_QUAL_CYC[bfs_pkg::CNT_W-1:0];
    localparam logic [bfs_pkg::CNT_W-1:0] PG_LIM = PG_BLANK_CYC[bfs_pkg::CNT_W-1:0];
    localparam logic [bfs_pkg::CNT_W-1:0] SS_LIM = SS_CYC[bfs_pkg::CNT_W-1:0];
    localparam logic [bfs_pkg::HIC_W-1:0] HIC_LIM =
        bfs_pkg::HICCUP_SS_COUNT[bfs_pkg::HIC_W-1:0];

    // Two-stage synchronisers for all pin and comparator inputs
    localparam int unsigned NSYNC = bfs_pkg::SYNC_N;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    // Named bit positions, so a reordered list cannot swap two flags
    assign raw[bfs_pkg::SYNC_EN]       = enable_i;
    assign raw[bfs_pkg::SYNC_LOCKOUT]  = supply_lockout_i;
    assign raw[bfs_pkg::SYNC_FB_UNDER] = fb_under_i;
    assign raw[bfs_pkg::SYNC_FB_OVER]  = fb_over_i;
    assign raw[bfs_pkg::SYNC_FB_WIN]   = fb_in_window_i;
    assign raw[bfs_pkg::SYNC_FB_ABOVE] = fb_above_ramp_i;
    assign raw[bfs_pkg::SYNC_HOT]      = thermal_hot_i;
    assign raw[bfs_pkg::SYNC_COOL]     = thermal_cool_i;
    assign raw[bfs_pkg::SYNC_DCM]      = dcm_i;
    assign raw[bfs_pkg::SYNC_VALLEY]   = valley_over_limit_i;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                end else if (clk_en_i) begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    logic en_s;
    logic lockout_s;
    logic fb_under_s;
    logic fb_over_s;
    logic fb_win_s;
    logic fb_above_s;
    logic hot_s;
    logic cool_s;
    logic dcm_s;
    logic valley_s;
    assign en_s       = s2_q[bfs_pkg::SYNC_EN];
    assign lockout_s  = s2_q[bfs_pkg::SYNC_LOCKOUT];
    assign fb_under_s = s2_q[bfs_pkg::SYNC_FB_UNDER];
    assign fb_over_s  = s2_q[bfs_pkg::SYNC_FB_OVER];
    assign fb_win_s   = s2_q[bfs_pkg::SYNC_FB_WIN];
    assign fb_above_s = s2_q[bfs_pkg::SYNC_FB_ABOVE];
    assign hot_s      = s2_q[bfs_pkg::SYNC_HOT];
    assign cool_s     = s2_q[bfs_pkg::SYNC_COOL];
    assign dcm_s      = s2_q[bfs_pkg::SYNC_DCM];
    assign valley_s   = s2_q[bfs_pkg::SYNC_VALLEY];

    bfs_pkg::bfs_state_e state_q;
    logic [bfs_pkg::CNT_W-1:0] ss_cnt_q;
    logic [bfs_pkg::HIC_W-1:0] hic_cnt_q;
    logic uv_hit;
    logic powered;
    logic thermal_event;
    logic ss_done;
    logic hic_done;
    logic st_ss;
    logic st_run;
    logic st_hiccup;
    logic st_thermal;

    // State decodes shared by the output registers
    assign st_ss      = (state_q == bfs_pkg::BFS_SOFT_START);
    assign st_run     = (state_q == bfs_pkg::BFS_RUN);
    assign st_hiccup  = (state_q == bfs_pkg::BFS_HICCUP);
    assign st_thermal = (state_q == bfs_pkg::BFS_THERMAL);

    assign powered = en_s && !lockout_s;
    assign thermal_event = hot_s && !dcm_s;
    assign ss_done = (ss_cnt_q >= SS_LIM);
    // Unit count lags one unit, so the twentieth ends at limit minus one
    assign hic_done = (hic_cnt_q == HIC_LIM - bfs_pkg::HIC_ONE) && ss_done;

    // Undervoltage only qualified while running after soft start
    bfs_qual_cnt u_uv_qual (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .en_i     (clk_en_i),
        .cond_i   (fb_under_s && st_run),
        .limit_i  (UV_LIM),
        .hit_o    (uv_hit)
    );

    // Main sequencing state
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= bfs_pkg::BFS_OFF;
        end else if (clk_en_i) begin
            if (!powered) begin
                state_q <= bfs_pkg::BFS_OFF;
            end else begin
                unique case (state_q)
                    bfs_pkg::BFS_OFF: begin
                        state_q <= bfs_pkg::BFS_SOFT_START;
                    end
                    bfs_pkg::BFS_SOFT_START: begin
                        if (thermal_event) begin
                            state_q <= bfs_pkg::BFS_THERMAL;
                        end else if (ss_done) begin
                            state_q <= bfs_pkg::BFS_RUN;
                        end
                    end
                    bfs_pkg::BFS_RUN: begin
                        if (thermal_event) begin
                            state_q <= bfs_pkg::BFS_THERMAL;
                        end else if (uv_hit) begin
                            state_q <= bfs_pkg::BFS_HICCUP;
                        end
                    end
                    bfs_pkg::BFS_HICCUP: begin
                        if (thermal_event) begin
                            state_q <= bfs_pkg::BFS_THERMAL;
                        end else if (hic_done) begin
                            state_q <= bfs_pkg::BFS_SOFT_START;
                        end
                    end
                    bfs_pkg::BFS_THERMAL: begin
                        if (cool_s) begin
                            state_q <= bfs_pkg::BFS_SOFT_START;
                        end
                    end
                endcase
            end
        end
    end

    // Soft-start timer; reused as one unit of the hiccup wait
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ss_cnt_q <= bfs_pkg::CNT_ZERO;
        end else if (clk_en_i) begin
            if (state_q == bfs_pkg::BFS_SOFT_START || state_q == bfs_pkg::BFS_HICCUP) begin
                if (ss_done && state_q == bfs_pkg::BFS_HICCUP) begin
                    ss_cnt_q <= bfs_pkg::CNT_ZERO;
                end else if (!ss_done) begin
                    ss_cnt_q <= ss_cnt_q + bfs_pkg::CNT_ONE;
                end else begin
                    ss_cnt_q <= bfs_pkg::CNT_ZERO;
                end
            end else begin
                ss_cnt_q <= bfs_pkg::CNT_ZERO;
            end
        end
    end

    // Counts soft-start lengths spent in hiccup
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hic_cnt_q <= bfs_pkg::HIC_ZERO;
        end else if (clk_en_i) begin
            if (state_q != bfs_pkg::BFS_HICCUP) begin
                hic_cnt_q <= bfs_pkg::HIC_ZERO;
            end else if (ss_done && hic_cnt_q < HIC_LIM) begin
                hic_cnt_q <= hic_cnt_q + bfs_pkg::HIC_ONE;
            end
        end
    end

    // Switch enables; overvoltage gates without leaving the run state
    logic ov_active;
    logic switching;
    assign ov_active = fb_over_s && powered;
    assign switching = st_run || (st_ss && !fb_above_s);

    // High side also yields to the valley limit, cycle by cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_side_switch_en_o <= 1'b0;
        end else if (clk_en_i) begin
            // No soft start on clear: state never leaves run for this
            high_side_switch_en_o <= switching && !ov_active && !valley_s;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_side_switch_en_o <= 1'b0;
        end else if (clk_en_i) begin
            low_side_switch_en_o <= switching && !ov_active;
        end
    end

    // Trip flags and protection arming, one register per output
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            undervoltage_trip_o <= 1'b0;
        end else if (clk_en_i) begin
            undervoltage_trip_o <= st_hiccup;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overvoltage_trip_o <= 1'b0;
        end else if (clk_en_i) begin
            overvoltage_trip_o <= ov_active;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            thermal_trip_o <= 1'b0;
        end else if (clk_en_i) begin
            thermal_trip_o <= st_thermal;
        end
    end

    // Ramp stops in the cycle power is lost, so the limit never lags it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            soft_start_ramp_o <= 1'b0;
        end else if (clk_en_i) begin
            soft_start_ramp_o <= st_ss && powered;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            use_soft_start_reference_o <= 1'b0;
        end else if (clk_en_i) begin
            use_soft_start_reference_o <= st_ss && powered;
        end
    end

    // Valley limit armed from lockout release, soft start included
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valley_current_limit_en_o <= 1'b0;
        end else if (clk_en_i) begin
            valley_current_limit_en_o <= powered;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            short_circuit_trip_en_o <= 1'b0;
        end else if (clk_en_i) begin
            short_circuit_trip_en_o <= st_run;
        end
    end

    // Power good, blanked so short excursions do not toggle the pin
    logic pg_target;
    logic pg_q;
    logic pg_expire;
    logic [bfs_pkg::CNT_W-1:0] pg_cnt_q;
    assign pg_target = fb_win_s && st_run && !ov_active;
    assign pg_expire = (pg_target != pg_q) && (pg_cnt_q >= PG_LIM);

    // Blanking counter restarts whenever the target agrees again
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pg_cnt_q <= bfs_pkg::CNT_ZERO;
        end else if (clk_en_i) begin
            if (!st_run || pg_target == pg_q || pg_expire) begin
                pg_cnt_q <= bfs_pkg::CNT_ZERO;
            end else begin
                pg_cnt_q <= pg_cnt_q + bfs_pkg::CNT_ONE;
            end
        end
    end

    // Leaving run drops power good at once, without blanking
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pg_q <= 1'b0;
        end else if (clk_en_i) begin
            if (!st_run) begin
                pg_q <= 1'b0;
            end else if (pg_expire) begin
                pg_q <= pg_target;
            end
        end
    end

    // Open drain: output is always low, enable pulls the pin
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            power_good_out_o    <= 1'b0;
            power_good_out_oe_o <= 1'b1;
        end else if (clk_en_i) begin
            power_good_out_o    <= 1'b0;
            power_good_out_oe_o <= !pg_q;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/bfs_analog_model.sv
// Behavioural model of the feedback comparators and soft-start ramp
`timescale 1ns/1ps
`default_nettype none
module bfs_analog_model #(
    parameter logic [7:0] WIN_LO = 8'h5a,
    parameter logic [7:0] WIN_HI = 8'h6e
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ramp_run_i,
    input  wire logic [7:0] level_i,
    output logic            fb_under_o,
    output logic            fb_over_o,
    output logic            fb_in_window_o,
    output logic            fb_above_ramp_o
);
    logic [7:0] ramp_q;
    // Output level in percent of set point; ramp restarts on every soft start
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i || !ramp_run_i) begin
            ramp_q <= 8'h00;
        end else if (ramp_q < 8'hc8) begin
            ramp_q <= ramp_q + 8'h05;
        end
    end
    assign fb_under_o      = level_i < 8'h14;
    assign fb_over_o       = level_i > 8'h78;
    assign fb_in_window_o  = level_i >= WIN_LO && level_i <= WIN_HI;
    assign fb_above_ramp_o = level_i > ramp_q;
endmodule
`default_nettype wire

// >>> testbench/bfs_sequencer_properties.sv
// Port assertions for the buck fault sequencer
`timescale 1ns/1ps
`default_nettype none
module bfs_sequencer_chk #(
    parameter int unsigned PG_BLANK_CYC = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic enable_i,
    input wire logic fb_over_i,
    input wire logic fb_in_window_i,
    input wire logic valley_over_limit_i,
    input wire logic high_side_switch_en_o,
    input wire logic low_side_switch_en_o,
    input wire logic soft_start_ramp_o,
    input wire logic use_soft_start_reference_o,
    input wire logic valley_current_limit_en_o,
    input wire logic short_circuit_trip_en_o,
    input wire logic undervoltage_trip_o,
    input wire logic thermal_trip_o,
    input wire logic power_good_out_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic [7:0] win_q;
    // Saturates so a long good stretch never wraps to a short one
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i || !fb_in_window_i) begin
            win_q <= 8'h00;
        end else if (win_q != 8'hff) begin
            win_q <= win_q + 8'h01;
        end
    end
    a_ov_both_off: assert property ((fb_over_i && clk_en_i)[*4] |->
        !high_side_switch_en_o && !low_side_switch_en_o) else $error("switch on in overvoltage");
    a_uv_both_off: assert property (undervoltage_trip_o |->
        !high_side_switch_en_o && !low_side_switch_en_o) else $error("switch on in hiccup");
    a_hot_both_off: assert property (thermal_trip_o |->
        !high_side_switch_en_o && !low_side_switch_en_o) else $error("switch on when hot");
    a_valley_hs_off: assert property ((valley_over_limit_i && clk_en_i)[*4] |->
        !high_side_switch_en_o) else $error("high side on above valley limit");
    a_disabled_pg_low: assert property ((!enable_i && clk_en_i)[*7] |->
        power_good_out_oe_o && !high_side_switch_en_o) else $error("active while disabled");
    a_ss_protect: assert property (soft_start_ramp_o |->
        valley_current_limit_en_o && !short_circuit_trip_en_o) else $error("soft start arming");
    a_ss_reference: assert property (use_soft_start_reference_o == soft_start_ramp_o)
        else $error("reference select differs from ramp");
    a_uv_from_run: assert property ($rose(undervoltage_trip_o) |->
        $past(short_circuit_trip_en_o)) else $error("undervoltage outside run");
    a_pg_blanked: assert property ($fell(power_good_out_oe_o) |->
        int'(win_q) > PG_BLANK_CYC) else $error("power good released too early");
    c_hiccup: cover property ($rose(undervoltage_trip_o));
    c_thermal: cover property ($rose(thermal_trip_o));
    c_pg_good: cover property ($fell(power_good_out_oe_o));
endmodule
bind bfs_sequencer bfs_sequencer_chk #(.PG_BLANK_CYC(PG_BLANK_CYC)) bfs_sequencer_chk_inst (
    .clk_i, .resetn_i, .clk_en_i, .enable_i, .fb_over_i, .fb_in_window_i, .valley_over_limit_i,
    .high_side_switch_en_o, .low_side_switch_en_o, .soft_start_ramp_o,
    .use_soft_start_reference_o, .valley_current_limit_en_o, .short_circuit_trip_en_o,
    .undervoltage_trip_o, .thermal_trip_o, .power_good_out_oe_o);
`default_nettype wire

// >>> testbench/test_buck_fault_sequencer.sv
// Self-checking testbench for the buck fault sequencer
`timescale 1ns/1ps
`default_nettype none
module test_buck_fault_sequencer;
    localparam int SS = 20;
    logic       clk_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic       enable_i = 1'b0;
    logic       lockout = 1'b1;
    logic       hot = 1'b0;
    logic       cool = 1'b0;
    logic       dcm = 1'b0;
    logic       valley = 1'b0;
    logic [7:0] level = 8'h64;
    logic       under, over, win, above;
    logic       hs, ls, ramp, vlim, short_circuit_trip, uvt, ovt, tht, pgoe, sref, pgo;
    int         bad_count = 0;
    int         n_checks = 0;
    int         cyc = 0;
    always #5 clk_i = ~clk_i;
    bfs_sequencer #(.UV_QUAL_CYC(8), .PG_BLANK_CYC(8), .SS_CYC(SS)) bfs_sequencer_inst (
        .clk_i, .resetn_i, .clk_en_i(1'b1), .enable_i, .supply_lockout_i(lockout),
        .fb_under_i(under), .fb_over_i(over), .fb_in_window_i(win), .fb_above_ramp_i(above),
        .thermal_hot_i(hot), .thermal_cool_i(cool), .dcm_i(dcm), .valley_over_limit_i(valley),
        .high_side_switch_en_o(hs), .low_side_switch_en_o(ls), .soft_start_ramp_o(ramp),
        .use_soft_start_reference_o(sref), .valley_current_limit_en_o(vlim),
        .short_circuit_trip_en_o(short_circuit_trip), .undervoltage_trip_o(uvt), .overvoltage_trip_o(ovt),
        .thermal_trip_o(tht), .power_good_out_o(pgo), .power_good_out_oe_o(pgoe));
    bfs_analog_model bfs_analog_model_inst (.clk_i, .resetn_i, .ramp_run_i(ramp),
        .level_i(level), .fb_under_o(under), .fb_over_o(over), .fb_in_window_o(win),
        .fb_above_ramp_o(above));
    task automatic check(input string name, input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Whole run needs about 1200 cycles; a hang is cut well after that
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            results();
        end
    end
    task automatic to_run;
        for (int i = 0; i < 1000 && short_circuit_trip !== 1'b1; i++) step(1);
        check("run reached", short_circuit_trip, 1'b1);
        step(20);
    endtask
    task automatic t_start;
        check("pg at reset", pgoe, 1'b1);
        enable_i = 1'b1;
        step(6);
        check("ramp in lockout", ramp, 1'b0);
        lockout = 1'b0;
        step(5);
        check("ramp", ramp, 1'b1);
        check("valley limit", vlim, 1'b1);
        check("short trip", short_circuit_trip, 1'b0);
        check("pg in soft start", pgoe, 1'b1);
        check("ramp reference", sref, 1'b1);
        level = 8'h82;
        step(4);
        check("ov in soft start", ovt, 1'b1);
        level = 8'h64;
        to_run();
        check("high side", hs, 1'b1);
        check("pg in run", pgoe, 1'b0);
        check("pg pin data", pgo, 1'b0);
        check("fixed reference", sref, 1'b0);
    endtask
    task automatic t_over_valley;
        level = 8'h82;
        step(4);
        check("hs over", hs, 1'b0);
        check("ls over", ls, 1'b0);
        level = 8'h64;
        step(4);
        check("hs resume", hs, 1'b1);
        check("no soft start", ramp, 1'b0);
        valley = 1'b1;
        step(4);
        check("hs valley", hs, 1'b0);
        check("ls valley", ls, 1'b1);
        valley = 1'b0;
    endtask
    task automatic t_pg;
        level = 8'h32;
        step(5);
        level = 8'h64;
        step(15);
        check("pg glitch", pgoe, 1'b0);
        level = 8'h32;
        step(20);
        check("pg out of window", pgoe, 1'b1);
        level = 8'h64;
        step(20);
        check("pg back", pgoe, 1'b0);
    endtask
    task automatic t_uv;
        int n;
        level = 8'h0a;
        step(5);
        level = 8'h64;
        step(10);
        check("uv brief", uvt, 1'b0);
        level = 8'h0a;
        for (int i = 0; i < 40 && uvt !== 1'b1; i++) step(1);
        check("uv trip", uvt, 1'b1);
        check("hs uv", hs, 1'b0);
        check("ls uv", ls, 1'b0);
        check("pg uv", pgoe, 1'b1);
        for (n = 0; n < 1000 && ramp !== 1'b1; n++) step(1);
        check("hiccup length", n >= 20 * SS && n <= 20 * (SS + 1) + 5, 1'b1);
        step(SS - 2);
        check("uv in soft start", uvt, 1'b0);
        for (int i = 0; i < 40 && uvt !== 1'b1; i++) step(1);
        check("uv retry", uvt, 1'b1);
        level = 8'h64;
        to_run();
    endtask
    task automatic t_thermal;
        dcm = 1'b1;
        hot = 1'b1;
        step(10);
        check("dcm mask", tht, 1'b0);
        dcm = 1'b0;
        step(5);
        check("thermal", tht, 1'b1);
        check("hs hot", hs, 1'b0);
        hot = 1'b0;
        step(10);
        check("wait cool", tht, 1'b1);
        cool = 1'b1;
        step(5);
        check("restart", ramp, 1'b1);
        cool = 1'b0;
        to_run();
    endtask
    task automatic t_prebias;
        enable_i = 1'b0;
        step(10);
        check("off hs", hs, 1'b0);
        check("off pg", pgoe, 1'b1);
        level = 8'h3c;
        enable_i = 1'b1;
        step(7);
        check("prebias hs", hs, 1'b0);
        check("prebias ls", ls, 1'b0);
        for (int i = 0; i < 40 && hs !== 1'b1; i++) step(1);
        check("ramp overtakes", ramp, 1'b1);
        level = 8'h64;
    endtask
    initial begin
        step(8);
        resetn_i = 1'b1;
        step(2);
        t_start();
        t_over_valley();
        t_pg();
        t_uv();
        t_thermal();
        t_prebias();
        results();
    end
endmodule
`default_nettype wire
